// [exec_pkg.sv]
// How it works
// - 1010 00tx copies a latch byte to file
// - t selects latch byte; latch, flags untouched
// - latch keeps word from program memory read
// - 1010 01tx copies file byte into latch
// - t selects latch byte; other byte kept
// - t=0,i=0 write loads low byte, pointer kept
// - 0011 0011 skips next instruction when zero
// - test: one cycle, two on skip, writes only the skip flag
// - 1011 0100 xors literal into working register
// - 0000 110d xors file register, updates zero
// - d=0 result to working, d=1 to file
// - program write stores latch, then bumps pointer if i=1
package exec_pkg;
  // apb register byte offsets
  localparam logic [7:0] REG_INSTR     = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_WORK      = 8'h08;
  localparam logic [7:0] REG_LATCH     = 8'h0c;
  localparam logic [7:0] REG_POINTER   = 8'h10;
  localparam logic [7:0] REG_FILE_ADDR = 8'h14;
  localparam logic [7:0] REG_FILE_DATA = 8'h18;
  localparam logic [7:0] REG_CYCLES    = 8'h1c;
  // status register bit positions
  localparam int STAT_BUSY = 0;
  localparam int STAT_SKIP = 1;
  localparam int STAT_ZERO = 2;
  // opcode patterns on the upper instruction bits
  localparam logic [5:0] OP_LATCH_RD  = 6'h28;
  localparam logic [5:0] OP_LATCH_WR  = 6'h29;
  localparam logic [5:0] OP_PROG_WR   = 6'h2b;
  localparam logic [7:0] OP_TEST_ZERO = 8'h33;
  localparam logic [7:0] OP_XOR_LIT   = 8'hb4;
  localparam logic [6:0] OP_XOR_REG   = 7'h06;
  // four clock phases per instruction cycle
  localparam logic [1:0] Q_DECODE  = 2'h0;
  localparam logic [1:0] Q_READ    = 2'h1;
  localparam logic [1:0] Q_PROCESS = 2'h2;
  localparam logic [1:0] Q_WRITE   = 2'h3;
  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam int FILE_DEPTH = 256;
endpackage

// [alu_if.sv]
`timescale 1ns/1ps
// operands and result between the core and its xor unit
interface alu_if;
  logic [7:0] op_a;   // first operand
  logic [7:0] op_b;   // second operand
  logic [7:0] result; // xor result
  logic       zero;   // result is zero
  modport core (output op_a, output op_b, input result, input zero);
  modport unit (input op_a, input op_b, output result, output zero);
endinterface

// [xor_zero_unit.sv]
`timescale 1ns/1ps
module xor_zero_unit (
  // operand side
  alu_if.unit alu
);
  // plain xor with a zero detect; a zero first operand turns it into a test
  always_comb begin
    alu.result = alu.op_a ^ alu.op_b;
    alu.zero   = ((alu.op_a ^ alu.op_b) == 8'h00);
  end
endmodule

// [table_latch_xor_skip_exec.sv]
`timescale 1ns/1ps
module table_latch_xor_skip_exec
  import exec_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // program memory write side
  output logic             prog_wr_en,
  output logic      [15:0] prog_addr,
  output logic      [15:0] prog_wdata,
  // program memory read return, same clock
  input  wire logic        prog_rd_valid,
  input  wire logic [15:0] prog_rd_data
);

  // execution sequence
  typedef enum logic [1:0] {
    ST_IDLE,   // waiting for an instruction
    ST_WAIT,   // instruction held until the next decode phase
    ST_EXEC,   // first instruction cycle
    ST_EXEC2   // second cycle: program write or skipped slot
  } exec_e;

  // whole module state
  typedef struct packed {
    exec_e                          state;
    logic [1:0]                     q;          // phase divider
    logic [15:0]                    instr;      // instruction in flight
    logic [7:0]                     work;       // working register
    logic                           zero;       // zero status flag
    logic [15:0]                    latch;      // table latch
    logic [15:0]                    pointer;    // table pointer
    logic [7:0]                     faddr;      // apb window into file
    logic [FILE_DEPTH-1:0][7:0]     file;       // file registers
    logic [7:0]                     operand;    // value read in q2
    logic [7:0]                     result;     // value made in q3
    logic                           res_zero;   // zero of result
    logic                           skip_pend;  // next instruction is dropped
    logic [15:0]                    cycles;     // instruction cycles run
    logic [31:0]                    prdata;
    logic                           pready;
    logic                           pslverr;
    logic                           prog_wr_en;
    logic [15:0]                    prog_addr;
    logic [15:0]                    prog_wdata;
  } state_s;

  state_s r;    // registered state
  state_s nxt;  // next state

  // the xor unit is shared by both xor forms and the zero test, so the
  // skip decision needs no second comparator
  alu_if alu ();  // link to the xor unit

  // decode fields of the instruction in flight
  logic [7:0] opc;        // upper byte
  logic [7:0] fsel;       // file address or literal
  logic       t_bit;      // latch byte select
  logic       i_bit;      // pointer increment / destination
  logic       is_lrd;
  logic       is_lwr;
  logic       is_pwr;
  logic       is_tst;
  logic       is_xlit;
  logic       is_xreg;
  logic       busy;
  logic       access;     // apb access phase completing
  logic       mapped;     // address hits a register
  logic [31:0] rd_word;   // read mux

  // opcode decode
  // unknown opcodes match nothing and run as a one-cycle no-op
  always_comb begin
    opc     = r.instr[15:8];
    fsel    = r.instr[7:0];
    t_bit   = r.instr[9];
    i_bit   = r.instr[8];
    is_lrd  = (opc[7:2] == OP_LATCH_RD);
    is_lwr  = (opc[7:2] == OP_LATCH_WR);
    is_pwr  = (opc[7:2] == OP_PROG_WR);
    is_tst  = (opc == OP_TEST_ZERO);
    is_xlit = (opc == OP_XOR_LIT);
    is_xreg = (opc[7:1] == OP_XOR_REG);
  end

  // xor unit operands: the test uses a zero first operand to detect f == 0
  always_comb begin
    alu.op_a = is_tst ? RST_BYTE : r.work;
    alu.op_b = is_xlit ? fsel : r.operand;
  end

  xor_zero_unit u_alu (
    .alu (alu.unit)
  );

  // register read mux and address decode
  always_comb begin
    busy    = (r.state != ST_IDLE);
    access  = psel && penable && r.pready;
    mapped  = 1'b1;
    rd_word = 32'h0000_0000;
    case (paddr)
      REG_INSTR:     rd_word = {16'h0000, r.instr};
      REG_STATUS: begin
        rd_word[STAT_BUSY] = busy;
        rd_word[STAT_SKIP] = r.skip_pend;
        rd_word[STAT_ZERO] = r.zero;
      end
      REG_WORK:      rd_word = {24'h000000, r.work};
      REG_LATCH:     rd_word = {16'h0000, r.latch};
      REG_POINTER:   rd_word = {16'h0000, r.pointer};
      REG_FILE_ADDR: rd_word = {24'h000000, r.faddr};
      REG_FILE_DATA: rd_word = {24'h000000, r.file[r.faddr]};
      REG_CYCLES:    rd_word = {16'h0000, r.cycles};
      default:       mapped  = 1'b0;  // unmapped: error, reads zero
    endcase
  end

  // next state
  // one pass builds the whole next state; later assignments win, so an
  // executing latch write overrides only its selected byte of a same-edge latch refill
  always_comb begin
    nxt            = r;
    nxt.q          = r.q + 2'h1;     // free-running phase divider
    nxt.prog_wr_en = 1'b0;           // program write strobe is one clock

    // apb setup: answer one clock later with data and error already flopped
    nxt.pready = psel && !penable;
    if (psel && !penable) begin
      nxt.prdata  = mapped ? rd_word : 32'h0000_0000;
      // writes are refused while an instruction runs to avoid racing it
      nxt.pslverr = !mapped || (pwrite && busy);
    end else if (!psel) begin
      nxt.pslverr = 1'b0;
    end

    // rule 3: a table read return refills the whole latch
    if (prog_rd_valid) begin
      nxt.latch = prog_rd_data;
    end

    // apb write takes effect at the completing access edge
    if (access && pwrite && !r.pslverr) begin
      case (paddr)
        REG_INSTR: begin
          if (r.skip_pend) begin
            nxt.skip_pend = 1'b0;
          end else begin
            nxt.instr = pwdata[15:0];
            nxt.state = ST_WAIT;
          end
        end
        REG_STATUS:    nxt.zero = pwdata[STAT_ZERO];
        REG_WORK:      nxt.work = pwdata[7:0];
        REG_LATCH:     nxt.latch = pwdata[15:0];
        REG_POINTER:   nxt.pointer = pwdata[15:0];
        REG_FILE_ADDR: nxt.faddr = pwdata[7:0];
        REG_FILE_DATA: nxt.file[r.faddr] = pwdata[7:0];
        default: begin
          // unmapped writes are ignored
        end
      endcase
    end

    // instruction sequencing on the four phases
    case (r.state)
      ST_IDLE: begin
        // nothing to do
      end
      ST_WAIT: begin
        // start on the next decode phase
        // aligning to the divider costs up to four clocks of latency
        if (r.q == Q_WRITE) begin
          nxt.state = ST_EXEC;
        end
      end
      ST_EXEC: begin
        case (r.q)
          Q_DECODE: begin
            // decode is combinational on the held instruction
          end
          Q_READ: begin
            nxt.operand = r.file[fsel];
          end
          Q_PROCESS: begin
            nxt.result   = alu.result;
            nxt.res_zero = alu.zero;
          end
          Q_WRITE: begin
            nxt.cycles = r.cycles + 16'h0001;
            nxt.state  = ST_IDLE;
            if (is_lrd) begin
              // latch and flags stay as they are
              nxt.file[fsel] = t_bit ? r.latch[15:8] : r.latch[7:0];
            end else if (is_lwr || is_pwr) begin
              // only the selected byte moves
              if (t_bit) begin
                nxt.latch[15:8] = r.operand;
              end else begin
                nxt.latch[7:0] = r.operand;
              end
              if (is_pwr) begin
                nxt.state = ST_EXEC2;
              end
            end else if (is_tst) begin
              // only the skip flag is written, on zero, which also runs a dead cycle
              if (r.res_zero) begin
                nxt.state     = ST_EXEC2;
                nxt.skip_pend = 1'b1;
              end
            end else if (is_xlit) begin
              nxt.work = r.result;
              nxt.zero = r.res_zero;
            end else if (is_xreg) begin
              nxt.zero = r.res_zero;
              if (i_bit) begin
                nxt.file[fsel] = r.result;
              end else begin
                nxt.work = r.result;
              end
            end
          end
          default: begin
            // unreachable phase code
          end
        endcase
      end
      ST_EXEC2: begin
        // a skipped slot only counts the dead cycle
        if (r.q == Q_WRITE) begin
          nxt.cycles = r.cycles + 16'h0001;
          nxt.state  = ST_IDLE;
          if (is_pwr) begin
            // whole latch to the pointed word, then optional increment
            nxt.prog_wr_en = 1'b1;
            nxt.prog_addr  = r.pointer;
            nxt.prog_wdata = r.latch;
            if (i_bit) begin
              nxt.pointer = r.pointer + 16'h0001;
            end
          end
        end
      end
      default: begin
        nxt.state = ST_IDLE;
      end
    endcase
  end

  // state register
  // only constants in the reset branch; the file array clears to zero too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.state      <= ST_IDLE;
      r.q          <= Q_DECODE;
      r.instr      <= RST_WORD;
      r.work       <= RST_BYTE;
      r.zero       <= 1'b0;
      r.latch      <= RST_WORD;
      r.pointer    <= RST_WORD;
      r.faddr      <= RST_BYTE;
      r.file       <= '0;
      r.operand    <= RST_BYTE;
      r.result     <= RST_BYTE;
      r.res_zero   <= 1'b0;
      r.skip_pend  <= 1'b0;
      r.cycles     <= RST_WORD;
      r.prdata     <= 32'h0000_0000;
      r.pready     <= 1'b0;
      r.pslverr    <= 1'b0;
      r.prog_wr_en <= 1'b0;
      r.prog_addr  <= RST_WORD;
      r.prog_wdata <= RST_WORD;
    end else begin
      r <= nxt;
    end
  end

  // outputs straight from flops
  // nothing is decoded on the way out, so the bus sees clean edges
  assign prdata     = r.prdata;
  assign pready     = r.pready;
  assign pslverr    = r.pslverr;
  assign prog_wr_en = r.prog_wr_en;
  assign prog_addr  = r.prog_addr;
  assign prog_wdata = r.prog_wdata;

endmodule

// [table_latch_xor_skip_exec_assertions.sv]
`timescale 1ns/1ps
module exec_checker
  import exec_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb side
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // program memory write side
  input wire logic        prog_wr_en,
  input wire logic [15:0] prog_addr,
  input wire logic [15:0] prog_wdata
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // the two phases of one transfer
  sequence s_setup; psel && !penable; endsequence
  sequence s_done; psel && penable && pready; endsequence
  property p_answer; s_setup |=> s_done; endproperty
  property p_one_cycle; pready |=> !pready; endproperty
  property p_unmapped; (s_done and (paddr > REG_CYCLES)) |-> pslverr; endproperty
  property p_err_zero; (s_done and (pslverr && !pwrite)) |-> prdata == 32'h0; endproperty
  property p_read_ok;
    (s_done and (!pwrite && paddr <= REG_CYCLES && paddr[1:0] == 2'h0)) |-> !pslverr;
  endproperty
  property p_upper_zero; (s_done and (!pwrite && paddr == REG_WORK)) |-> prdata[31:8] == 24'h0; endproperty
  // the strobe is one clock; address and word move only with it
  property p_strobe; prog_wr_en |=> !prog_wr_en; endproperty
  property p_held; !prog_wr_en |-> $stable(prog_addr) && $stable(prog_wdata); endproperty
  a_answer: assert property (p_answer) else $error("no answer after setup");
  a_one_cycle: assert property (p_one_cycle) else $error("ready longer than one cycle");
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
  a_err_zero: assert property (p_err_zero) else $error("refused read returned data");
  a_read_ok: assert property (p_read_ok) else $error("mapped read refused");
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
  a_strobe: assert property (p_strobe) else $error("write strobe too long");
  a_held: assert property (p_held) else $error("write address moved without strobe");
endmodule
bind table_latch_xor_skip_exec exec_checker chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .prog_wr_en, .prog_addr, .prog_wdata);

// [prog_mem_model.sv]
`timescale 1ns/1ps
module prog_mem_model (
  // clock
  input wire logic        pclk,
  // write side from the core
  input wire logic        prog_wr_en,
  input wire logic [15:0] prog_addr,
  input wire logic [15:0] prog_wdata,
  // read return to the core
  output logic            prog_rd_valid,
  output logic [15:0]     prog_rd_data
);
  logic [15:0] mem [logic [15:0]]; // sparse program store
  initial begin
    prog_rd_valid = 1'b0;
    prog_rd_data  = 16'h0000;
  end
  // store the word at the strobe's sampling edge
  always @(posedge pclk) begin
    if (prog_wr_en === 1'b1) mem[prog_addr] = prog_wdata;
  end
  // one return pulse; data inverts after so a stale word is never seen
  task automatic load(input logic [15:0] d);
    @(posedge pclk);
    prog_rd_valid <= 1'b1;
    prog_rd_data  <= d;
    @(posedge pclk);
    prog_rd_valid <= 1'b0;
    prog_rd_data  <= ~d;
  endtask
endmodule

// [tb.sv]
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
  $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb;
  import exec_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        prog_wr_en, prog_rd_valid, rd_e;
  logic [7:0]  paddr;
  logic [15:0] prog_addr, prog_wdata, prog_rd_data, cyc;
  logic [31:0] pwdata, prdata, rd_d;
  int          mismatches, n_tests;
  table_latch_xor_skip_exec dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .prog_wr_en, .prog_addr, .prog_wdata, .prog_rd_valid, .prog_rd_data);
  prog_mem_model pm (.pclk, .prog_wr_en, .prog_addr, .prog_wdata, .prog_rd_valid, .prog_rd_data);
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // one apb transfer; request held until ready is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // ready, data and error are taken at the rising edge that samples them
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      summarize();
    end
    rd_d    = prdata;
    rd_e    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic cr(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(nm, e, rd_d)
  endtask
  task automatic setf(input logic [7:0] a, input logic [7:0] d);
    wr(REG_FILE_ADDR, {24'h0, a});
    wr(REG_FILE_DATA, {24'h0, d});
  endtask
  // poll busy until the running instruction is done, bounded
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      xfer(1'b0, REG_STATUS, 32'h0);
      n++;
    end while (rd_d[STAT_BUSY] !== 1'b0 && n < 20);
    if (rd_d[STAT_BUSY] !== 1'b0) begin
      mismatches++;
      summarize();
    end
  endtask
  // start one instruction and wait for it
  task automatic ex(input logic [15:0] i);
    wr(REG_INSTR, {16'h0, i});
    wait_idle();
  endtask
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    paddr = 8'h00;
    pwdata = 32'h0;
    mismatches = 0;
    n_tests = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    cr("status", REG_STATUS, 32'h0);
    cr("latch", REG_LATCH, 32'h0);
    setf(8'h10, 8'hb7);
    ex(16'ha410);
    cr("latch", REG_LATCH, 32'h00b7);
    ex(16'ha610);
    cr("latch", REG_LATCH, 32'hb7b7);
    pm.load(16'h1234);
    wr(REG_STATUS, 32'h4);
    ex(16'ha220);
    ex(16'ha021);
    wr(REG_FILE_ADDR, 32'h20);
    cr("file", REG_FILE_DATA, 32'h12);
    wr(REG_FILE_ADDR, 32'h21);
    cr("file", REG_FILE_DATA, 32'h34);
    cr("latch", REG_LATCH, 32'h1234);
    cr("flags", REG_STATUS, 32'h4);
    $display("latch tests done");
    setf(8'h10, 8'h53);
    wr(REG_LATCH, 32'haa55);
    wr(REG_POINTER, 32'ha356);
    ex(16'hac10);
    cr("latch", REG_LATCH, 32'haa53);
    cr("pointer", REG_POINTER, 32'ha356);
    `CHK("mem", 16'haa53, pm.mem[16'ha356])
    ex(16'haf10);
    cr("pointer", REG_POINTER, 32'ha357);
    `CHK("mem", 16'h5353, pm.mem[16'ha356])
    $display("program write done");
    wr(REG_WORK, 32'hb5);
    ex(16'hb4af);
    cr("work", REG_WORK, 32'h1a);
    cr("flags", REG_STATUS, 32'h0);
    ex(16'hb41a);
    cr("flags", REG_STATUS, 32'h4);
    wr(REG_WORK, 32'hb5);
    setf(8'h10, 8'haf);
    ex(16'h0d10);
    cr("file", REG_FILE_DATA, 32'h1a);
    cr("work", REG_WORK, 32'hb5);
    ex(16'h0c10);
    cr("work", REG_WORK, 32'haf);
    cr("flags", REG_STATUS, 32'h0);
    $display("xor done");
    setf(8'h30, 8'h00);
    xfer(1'b0, REG_CYCLES, 32'h0);
    cyc = rd_d[15:0];
    ex(16'h3330);
    cr("cycles", REG_CYCLES, {16'h0, cyc + 16'h2});
    cr("flags", REG_STATUS, 32'h2);
    wr(REG_INSTR, 32'hb4ff);
    cr("work", REG_WORK, 32'haf);
    setf(8'h31, 8'h05);
    xfer(1'b0, REG_CYCLES, 32'h0);
    cyc = rd_d[15:0];
    ex(16'h3331);
    cr("cycles", REG_CYCLES, {16'h0, cyc + 16'h1});
    ex(16'hb4ff);
    cr("work", REG_WORK, 32'h50);
    xfer(1'b1, 8'h40, 32'h1);
    `CHK("err", 1'b1, rd_e)
    xfer(1'b0, 8'h40, 32'h0);
    `CHK("data", 32'h0, rd_d)
    wr(REG_INSTR, 32'hb400);
    xfer(1'b1, REG_LATCH, 32'h77);
    `CHK("busy err", 1'b1, rd_e)
    wait_idle();
    cr("latch", REG_LATCH, 32'h5353);
    cr("work", REG_WORK, 32'h50);
    $display("skip and map tests done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    cr("latch", REG_LATCH, 32'h0);
    cr("pointer", REG_POINTER, 32'h0);
    $display("reset tests done");
    summarize();
  end
endmodule
